// ===== core/edoc_ctrl.sv
`timescale 1ns/10ps
module edoc_ctrl #(
  parameter int unsigned PWRUP_CYC   = edoc_pkg::PWRUP_CYC,
  parameter int unsigned REF_INT_CYC = edoc_pkg::REF_INT_CYC
) (
  input  wire logic                        clock,
  input  wire logic                        rst,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire edoc_pkg::edoc_req_t         req,
  output logic                             rsp_valid,
  output logic [edoc_pkg::DATA_W-1:0]      rsp_rdata,
  output logic                             init_done,
  output edoc_pkg::edoc_pins_t             pins,
  input  wire logic [edoc_pkg::DATA_W-1:0] dq_in,
  output logic [edoc_pkg::DATA_W-1:0]      dq_out,
  output logic [edoc_pkg::DATA_W-1:0]      dq_oe
);
  edoc_pkg::edoc_state_t state_q;
  edoc_pkg::edoc_req_t   cur_q;
  edoc_pkg::edoc_pins_t  pins_q;
  logic [31:0]           pwr_cnt_q;
  logic [31:0]           ref_cnt_q;
  logic [3:0]            wake_left_q;
  logic                  ref_due_q;
  logic                  ref_lapsed_q;
  logic                  t_load;
  logic [15:0]           t_val;
  logic                  t_done;
  logic                  dq_drive_q;
  logic                  rsp_valid_q;
  logic [15:0]           rdata_q;

  function automatic logic [15:0] cyc(input int unsigned n);
    cyc = 16'(n - 1);
  endfunction : cyc

  edoc_timer #(.W(edoc_pkg::TIMER_W)) u_timer (
    .clock (clock),
    .rst   (rst),
    .load  (t_load),
    .value (t_val),
    .done  (t_done)
  );

  // Power-up pause counter
  always_ff @(posedge clock) begin
    if (rst) begin
      pwr_cnt_q <= '0;
    end else if (pwr_cnt_q < PWRUP_CYC) begin
      pwr_cnt_q <= pwr_cnt_q + 32'h1;
    end
  end

  // Refresh interval; a slot that ends with its refresh still due means the period lapsed
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_cnt_q    <= '0;
      ref_due_q    <= 1'b0;
      ref_lapsed_q <= 1'b0;
    end else begin
      if (ref_cnt_q >= REF_INT_CYC - 1) begin
        ref_cnt_q <= '0;
        ref_due_q <= 1'b1;
        // Set wins over the clear below
        if (ref_due_q && state_q != edoc_pkg::EDOC_CNTREF_ROW) begin
          ref_lapsed_q <= 1'b1;
        end
      end else begin
        ref_cnt_q <= ref_cnt_q + 32'h1;
        if (state_q == edoc_pkg::EDOC_CNTREF_ROW && t_done) begin
          ref_due_q <= 1'b0;
        end
        if (state_q == edoc_pkg::EDOC_POWERUP) begin
          ref_lapsed_q <= 1'b0;
        end
      end
    end
  end

  // Wake-up refreshes take priority, so ready stays low until all of them are done
  assign req_ready = (state_q == edoc_pkg::EDOC_IDLE) && !ref_due_q && !ref_lapsed_q && t_done &&
                     (wake_left_q == 4'h0);

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q     <= edoc_pkg::EDOC_POWERUP;
      cur_q       <= '0;
      pins_q      <= '{row_strobe_n: 1'b1, low_byte_col_strobe_n: 1'b1, high_byte_col_strobe_n: 1'b1,
                       write_en_n: 1'b1, out_en_n: 1'b1, addr: '0};
      wake_left_q <= 4'h0;
      init_done   <= 1'b0;
      dq_drive_q  <= 1'b0;
      rsp_valid_q <= 1'b0;
      rdata_q     <= 16'h0000;
    end else begin
      rsp_valid_q <= 1'b0;
      case (state_q)
        edoc_pkg::EDOC_POWERUP: begin
          init_done <= 1'b0;
          if (pwr_cnt_q >= PWRUP_CYC && t_done) begin
            wake_left_q <= 4'(edoc_pkg::WAKE_REFRESHES);
            state_q     <= edoc_pkg::EDOC_IDLE;
          end
        end
        edoc_pkg::EDOC_IDLE: begin
          if (ref_lapsed_q) begin
            state_q <= edoc_pkg::EDOC_POWERUP;
          end else if (t_done && (wake_left_q != 4'h0 || ref_due_q)) begin
            // Column strobes first: counter refresh, address ignored
            pins_q.low_byte_col_strobe_n  <= 1'b0;
            pins_q.high_byte_col_strobe_n <= 1'b0;
            pins_q.write_en_n             <= 1'b1;
            state_q <= edoc_pkg::EDOC_CNTREF_CS;
          end else if (req_valid && req_ready) begin
            cur_q             <= req;
            pins_q.addr       <= req.row;
            pins_q.row_strobe_n <= 1'b0;
            state_q           <= edoc_pkg::EDOC_ROW;
          end
        end
        edoc_pkg::EDOC_CNTREF_CS: begin
          if (t_done) begin
            pins_q.row_strobe_n <= 1'b0;
            state_q <= edoc_pkg::EDOC_CNTREF_ROW;
          end
        end
        edoc_pkg::EDOC_CNTREF_ROW: begin
          if (t_done) begin
            pins_q.row_strobe_n           <= 1'b1;
            pins_q.low_byte_col_strobe_n  <= 1'b1;
            pins_q.high_byte_col_strobe_n <= 1'b1;
            if (wake_left_q != 4'h0) begin
              wake_left_q <= wake_left_q - 4'h1;
              if (wake_left_q == 4'h1) begin
                init_done <= 1'b1;
              end
            end
            state_q <= edoc_pkg::EDOC_PRECH;
          end
        end
        edoc_pkg::EDOC_ROW: begin
          if (t_done) begin
            pins_q.addr <= 12'(cur_q.col);
            // Early write: enable falls before the column strobe; output enable stays high
            pins_q.write_en_n <= !cur_q.write;
            pins_q.out_en_n   <= cur_q.write;
            dq_drive_q        <= cur_q.write;
            state_q <= edoc_pkg::EDOC_COL;
          end
        end
        edoc_pkg::EDOC_COL: begin
          pins_q.low_byte_col_strobe_n  <= !cur_q.byte_en[0];
          pins_q.high_byte_col_strobe_n <= !cur_q.byte_en[1];
          state_q <= edoc_pkg::EDOC_CAS;
        end
        edoc_pkg::EDOC_CAS: begin
          if (t_done) begin
            if (!cur_q.write) begin
              // Column access governs once the column strobe is late
              rdata_q <= {cur_q.byte_en[1] ? dq_in[15:8] : 8'h00,
                          cur_q.byte_en[0] ? dq_in[7:0] : 8'h00};
              rsp_valid_q <= 1'b1;
            end else begin
              rsp_valid_q <= 1'b1;
            end
            // Raise output enable first so pins open before the strobes rise
            pins_q.out_en_n <= 1'b1;
            state_q <= edoc_pkg::EDOC_CAS_UP;
          end
        end
        edoc_pkg::EDOC_CAS_UP: begin
          pins_q.low_byte_col_strobe_n  <= 1'b1;
          pins_q.high_byte_col_strobe_n <= 1'b1;
          pins_q.row_strobe_n           <= 1'b1;
          pins_q.write_en_n             <= 1'b1;
          dq_drive_q                    <= 1'b0;
          state_q <= edoc_pkg::EDOC_PRECH;
        end
        edoc_pkg::EDOC_PRECH: begin
          // Precharge covers the turn-off delay from the later strobe edge
          if (t_done) begin
            state_q <= edoc_pkg::EDOC_IDLE;
          end
        end
        default: state_q <= edoc_pkg::EDOC_POWERUP;
      endcase
    end
  end

  // Timer loads on entry into each timed phase
  always_comb begin
    t_load = 1'b0;
    t_val  = 16'h0000;
    case (state_q)
      edoc_pkg::EDOC_IDLE: begin
        if (!ref_lapsed_q && t_done && (wake_left_q != 4'h0 || ref_due_q)) begin
          t_load = 1'b1;
          t_val  = cyc(edoc_pkg::CSR_CYC);
        end else if (!ref_lapsed_q && req_valid && req_ready) begin
          t_load = 1'b1;
          t_val  = cyc(edoc_pkg::RCD_CYC);
        end
      end
      edoc_pkg::EDOC_CNTREF_CS: if (t_done) begin
        t_load = 1'b1;
        t_val  = cyc(edoc_pkg::RAS_CYC);
      end
      edoc_pkg::EDOC_COL: begin
        t_load = 1'b1;
        t_val  = cyc(edoc_pkg::CAS_CYC);
      end
      edoc_pkg::EDOC_CAS_UP: begin
        t_load = 1'b1;
        t_val  = cyc(edoc_pkg::RP_CYC + edoc_pkg::OFF_CYC);
      end
      edoc_pkg::EDOC_CNTREF_ROW: if (t_done) begin
        t_load = 1'b1;
        t_val  = cyc(edoc_pkg::RP_CYC + edoc_pkg::CP_CYC);
      end
      default: begin
        t_load = 1'b0;
        t_val  = 16'h0000;
      end
    endcase
  end

  assign pins      = pins_q;
  assign dq_out    = cur_q.wdata;
  assign dq_oe     = {{8{dq_drive_q & cur_q.byte_en[1]}}, {8{dq_drive_q & cur_q.byte_en[0]}}};
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
endmodule : edoc_ctrl

// ===== core/edoc_pkg.sv
package edoc_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned PWRUP_US       = 200;
  localparam int unsigned PWRUP_CYC      = PWRUP_US * CLK_MHZ;
  localparam int unsigned WAKE_REFRESHES = 8;
  localparam int unsigned REF_MS         = 64;
  localparam int unsigned REF_ROWS       = 4096;
  localparam int unsigned REF_INT_CYC    = (REF_MS * 1000 * CLK_MHZ) / REF_ROWS;
  // Times in ns; counts rounded up for minimums
  localparam int unsigned T_RP_NS        = 40;
  localparam int unsigned T_RAS_NS       = 60;
  localparam int unsigned T_RCD_NS       = 14;
  localparam int unsigned T_CAS_NS       = 15;
  localparam int unsigned T_CP_NS        = 10;
  localparam int unsigned T_CSR_NS       = 5;
  localparam int unsigned T_OFF_NS       = 15;
  localparam int unsigned T_PC_NS        = 25;
  localparam int unsigned NS_PER_CYC     = 1000 / CLK_MHZ;
  localparam int unsigned RP_CYC   = (T_RP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned RAS_CYC  = (T_RAS_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned RCD_CYC  = (T_RCD_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned CAS_CYC  = (T_CAS_NS + NS_PER_CYC - 1) / NS_PER_CYC + 1;
  localparam int unsigned CP_CYC   = (T_CP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned CSR_CYC  = (T_CSR_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned OFF_CYC  = (T_OFF_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned PC_CYC   = (T_PC_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int unsigned ROW_W    = 12;
  localparam int unsigned COL_W    = 10;
  localparam int unsigned DATA_W   = 16;
  localparam int unsigned TIMER_W  = 16;

  typedef struct packed {
    logic                 write;
    logic [1:0]           byte_en;
    logic [ROW_W-1:0]     row;
    logic [COL_W-1:0]     col;
    logic [DATA_W-1:0]    wdata;
  } edoc_req_t;

  typedef struct packed {
    logic                 row_strobe_n;
    logic                 low_byte_col_strobe_n;
    logic                 high_byte_col_strobe_n;
    logic                 write_en_n;
    logic                 out_en_n;
    logic [ROW_W-1:0]     addr;
  } edoc_pins_t;

  typedef enum logic [3:0] {
    EDOC_POWERUP  = 4'h0,
    EDOC_IDLE     = 4'h1,
    EDOC_ROW      = 4'h3,
    EDOC_COL      = 4'h2,
    EDOC_CAS      = 4'h6,
    EDOC_CAS_UP   = 4'h7,
    EDOC_PRECH    = 4'h5,
    EDOC_CNTREF_CS  = 4'h4,
    EDOC_CNTREF_ROW = 4'hc
  } edoc_state_t;
endpackage : edoc_pkg

// ===== core/edoc_timer.sv
`timescale 1ns/10ps
module edoc_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] count_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= value;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Done ignores load: the controller loads on done, so a load term would close a loop
  assign done = (count_q == '0);
endmodule : edoc_timer

// ===== tb/edoc_ctrl_sva.sv
`timescale 1ns/10ps
module edoc_ctrl_sva #(
  parameter int unsigned PWRUP_CYC   = edoc_pkg::PWRUP_CYC,
  parameter int unsigned REF_INT_CYC = edoc_pkg::REF_INT_CYC
) (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        init_done,
  input wire edoc_pkg::edoc_pins_t        pins,
  input wire logic [edoc_pkg::DATA_W-1:0] dq_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic        lo_n;
  int unsigned since_rst_q;
  int unsigned cntref_cnt_q;
  int unsigned pc_gap_q;
  int unsigned ref_gap_q;
  assign lo_n = pins.low_byte_col_strobe_n;
  sequence s_cntref_start;
    $fell(pins.row_strobe_n) && !lo_n;
  endsequence
  sequence s_ras_low;
    (!pins.row_strobe_n) [*6];
  endsequence
  always_ff @(posedge clock) begin
    if (rst) since_rst_q <= 0;
    else if (since_rst_q < PWRUP_CYC) since_rst_q <= since_rst_q + 1;
  end
  // Restart the tally when wake-up is redone after a lapse
  always_ff @(posedge clock) begin
    if (rst || $fell(init_done)) cntref_cnt_q <= 0;
    else if ($fell(pins.row_strobe_n) && !lo_n) cntref_cnt_q <= cntref_cnt_q + 1;
  end
  // Starts saturated so the first low-byte strobe fall after reset, a wake-up refresh, is never flagged
  always_ff @(posedge clock) begin
    if (rst) pc_gap_q <= 255;
    else if ($fell(lo_n)) pc_gap_q <= 1;
    else if (pc_gap_q < 255) pc_gap_q <= pc_gap_q + 1;
  end
  always_ff @(posedge clock) begin
    if (rst || ($fell(pins.row_strobe_n) && !lo_n)) ref_gap_q <= 0;
    else if (ref_gap_q < 60000) ref_gap_q <= ref_gap_q + 1;
  end
  a_quiet_powerup: assert property (!pins.row_strobe_n |-> since_rst_q >= PWRUP_CYC)
    else $error("row strobe active during power-up wait");
  a_wake_count: assert property ($rose(init_done) |-> cntref_cnt_q >= 8)
    else $error("ready before eight wake-up refreshes");
  a_access_ready: assert property ($fell(pins.row_strobe_n) && lo_n |-> init_done)
    else $error("access started before wake-up");
  a_oe_write: assert property (dq_oe != 0 |-> pins.out_en_n && !pins.write_en_n)
    else $error("data driven outside an output-enable-high write");
  a_early_we: assert property ($fell(pins.write_en_n) |-> lo_n && pins.high_byte_col_strobe_n)
    else $error("write enable fell after a column strobe");
  a_cntref_order: assert property (s_cntref_start |-> !$past(lo_n) ##0 s_ras_low)
    else $error("counter refresh strobe order or width wrong");
  a_page_gap: assert property ($fell(lo_n) |-> pc_gap_q >= edoc_pkg::PC_CYC)
    else $error("column strobe falls too close");
  a_ref_rate: assert property (init_done |-> ref_gap_q <= 2 * REF_INT_CYC + 16)
    else $error("refresh interval exceeded while ready");
endmodule : edoc_ctrl_sva

bind edoc_ctrl edoc_ctrl_sva #(.PWRUP_CYC(PWRUP_CYC), .REF_INT_CYC(REF_INT_CYC)) edoc_ctrl_sva_i (
  .clock(clock), .rst(rst), .init_done(init_done), .pins(pins), .dq_oe(dq_oe));

// ===== tb/edoc_mem_model.sv
`timescale 1ns/10ps
module edoc_mem_model (
  input  wire logic                        clock,
  input  wire edoc_pkg::edoc_pins_t        pins,
  input  wire logic [edoc_pkg::DATA_W-1:0] dq_out,
  input  wire logic [edoc_pkg::DATA_W-1:0] dq_oe,
  output logic [edoc_pkg::DATA_W-1:0]      dq_in,
  output int unsigned                      refresh_cnt
);
  logic [15:0]          mem [logic [21:0]];
  edoc_pkg::edoc_pins_t p_q;
  logic [11:0]          row_q;
  logic [9:0]           col_q;
  logic                 cntref_q = 1'b0;
  logic [1:0]           cs_prev_n;
  logic [15:0]          rd;
  logic [15:0]          last_q = 16'h0000;
  logic [1:0]           cs_n;
  logic [1:0]           drv;
  initial refresh_cnt = 0;
  assign cs_n = {pins.high_byte_col_strobe_n, pins.low_byte_col_strobe_n};
  assign cs_prev_n = {p_q.high_byte_col_strobe_n, p_q.low_byte_col_strobe_n};
  always @(posedge clock) begin
    p_q <= pins;
    last_q <= dq_in;
    if (p_q.row_strobe_n && !pins.row_strobe_n) begin
      cntref_q <= !cs_n[0];
      if (!cs_n[0]) refresh_cnt <= refresh_cnt + 1;
      else row_q <= pins.addr;
    end
    for (int b = 0; b < 2; b++) begin
      if (cs_prev_n[b] && !cs_n[b] && !pins.row_strobe_n) begin
        col_q <= pins.addr[9:0];
        if (!pins.write_en_n && !cntref_q) mem[{row_q, pins.addr[9:0]}][8*b +: 8] <= dq_in[8*b +: 8];
      end
    end
  end
  // A released lane shows the inverse of its last level, so stale data never matches
  always @* begin
    rd = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : ~last_q;
    // Only early writes arrive, so a low write enable keeps the lanes released
    for (int b = 0; b < 2; b++) drv[b] = !cs_n[b] && !pins.out_en_n && pins.write_en_n && !cntref_q;
    for (int i = 0; i < 16; i++) dq_in[i] = dq_oe[i] ? dq_out[i] : (drv[i/8] ? rd[i] : ~last_q[i]);
  end
endmodule : edoc_mem_model

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  localparam int unsigned RINT = 400;
  logic                 clock     = 1'b0;
  logic                 rst       = 1'b1;
  logic                 req_valid = 1'b0;
  edoc_pkg::edoc_req_t  req       = '0;
  logic                 req_ready, rsp_valid, init_done;
  logic [15:0]          rsp_rdata, dq_in, dq_out, dq_oe;
  edoc_pkg::edoc_pins_t pins;
  int unsigned          refresh_cnt, n0;
  int unsigned          miscompares = 0;
  int unsigned          checks_done = 0;
  int unsigned          cycles      = 0;
  integer               seed        = 32'h85bb;
  logic [15:0]          ref_mem [logic [21:0]];
  logic [16:0]          exp_q [$];
  logic [21:0]          addr_l [$];
  logic [21:0]          a;
  logic [16:0]          e;
  edoc_ctrl #(.PWRUP_CYC(50), .REF_INT_CYC(RINT)) edoc_ctrl_i (.clock(clock), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .init_done(init_done),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  edoc_mem_model edoc_mem_model_i (.clock(clock), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .refresh_cnt(refresh_cnt));
  always #5 clock = ~clock;
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic access(input logic wr, input logic [1:0] be, input logic [21:0] ad, input logic [15:0] d);
    logic [15:0] m;
    int unsigned n;
    m = {{8{be[1]}}, {8{be[0]}}};
    n = 0;
    @(negedge clock);
    req_valid = 1'b1;
    req = '{wr, be, ad[21:10], ad[9:0], d};
    // Ready only moves on rising edges, so its value at the falling edge holds at the next take
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    @(posedge clock);
    check("req_taken", 16'(n < 2000), 16'h0001);
    if (wr) ref_mem[ad] = (ref_mem[ad] & ~m) | (d & m);
    exp_q.push_back({wr, ref_mem[ad] & m});
    @(negedge clock);
    req_valid = 1'b0;
  endtask : access
  task automatic drain();
    int unsigned n;
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(negedge clock);
      n++;
    end
    check("rsp_drained", 16'(exp_q.size()), 16'h0000);
  endtask : drain
  task automatic wait_init();
    int unsigned n;
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check("init_seen", {15'h0, init_done}, 16'h0001);
    check("wake_refreshes", 16'(refresh_cnt - n0), 16'h0008);
    $display("test wake-up done");
  endtask : wait_init
  // Timeout and response monitor share the clock edge; expectations are queued at take time
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check("rsp_extra", 16'h0001, 16'h0000);
      else begin
        e = exp_q.pop_front();
        if (!e[16]) check("rsp_rdata", rsp_rdata, e[15:0]);
      end
    end
    if (cycles == 8000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    n0 = 0;
    repeat (2) @(negedge clock);
    check("dq_oe_rst", dq_oe, 16'h0000);
    check("ras_rst", {15'h0, pins.row_strobe_n}, 16'h0001);
    rst = 1'b0;
    wait_init();
    for (int i = 0; i < 12; i++) begin
      a = 22'($random(seed));
      addr_l.push_back(a);
      access(1'b1, 2'h3, a, 16'($random(seed)));
      access(1'b1, 2'($random(seed)), a, 16'($random(seed)));
      access(1'b0, 2'($random(seed)), a, 16'h0000);
    end
    drain();
    $display("test byte lanes done");
    n0 = refresh_cnt;
    repeat (3 * RINT) @(negedge clock);
    check("refresh_kept", 16'(refresh_cnt - n0 >= 2), 16'h0001);
    check("still_ready", {15'h0, init_done}, 16'h0001);
    $display("test refresh rate done");
    rst = 1'b1;
    repeat (2) @(negedge clock);
    n0 = refresh_cnt;
    check("init_in_rst", {15'h0, init_done}, 16'h0000);
    rst = 1'b0;
    wait_init();
    foreach (addr_l[i]) access(1'b0, 2'h3, addr_l[i], 16'h0000);
    drain();
    $display("test reset recovery done");
    wrap_up();
  end
endmodule : tb
